// File: rtl/tdmcs_clkgen.sv
module tdmcs_clkgen (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // strap
    input  wire logic i_master,
    // generated link timing
    output logic      o_bclk,
    output logic      o_frame_pulse
);
    import tdmcs_pkg::*;

    typedef struct packed {
        logic [7:0] div;
        logic [7:0] bits;
        logic       bclk;
        logic       fp;
    } tdmcs_gen_s;

    tdmcs_gen_s s;
    tdmcs_gen_s next_s;

    always_comb begin
        next_s = s;
        if (i_master) begin
            if (s.div == 8'(BCLK_HALF_CYC - 1)) begin
                next_s.div  = 8'h00;
                next_s.bclk = ~s.bclk;
                if (!s.bclk) begin
                    // one pulse per 256 bit clocks, high in the last bit
                    next_s.bits = 8'(s.bits + 8'h01);
                    next_s.fp   = (next_s.bits == FRAME_LAST_BIT);
                end
            end else begin
                next_s.div = 8'(s.div + 8'h01);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_bclk        = s.bclk;
    assign o_frame_pulse = s.fp;
endmodule

// File: rtl/tdmcs_compand.sv
module tdmcs_compand (
    // linear sample in
    input  wire logic [15:0] i_sample,
    input  wire logic [1:0]  i_coding,
    // companded code out
    output logic      [7:0]  o_code
);
    import tdmcs_pkg::*;

    logic        mu;
    logic        neg;
    logic [15:0] pcm;
    logic [15:0] mag;
    logic [2:0]  seg;
    logic [3:0]  shift;
    logic [3:0]  mant;

    always_comb begin
        mu  = (i_coding == CODING_MULAW);
        neg = i_sample[15];
        seg = 3'h0;
        if (mu) begin
            pcm = 16'($signed(i_sample) >>> 2);
            mag = neg ? 16'(-pcm) : pcm;
            mag = 16'(mag + 16'(MU_BIAS));
            if (mag > MU_CLIP) begin
                mag = MU_CLIP;
            end
            for (int i = 0; i < 8; i++) begin
                if (mag[i + 5]) begin
                    seg = 3'(i);
                end
            end
            shift = {1'b0, seg} + 4'h1;
        end else begin
            pcm = 16'($signed(i_sample) >>> 3);
            mag = neg ? ~pcm : pcm;
            for (int i = 0; i < 8; i++) begin
                if (mag[i + 4]) begin
                    seg = 3'(i);
                end
            end
            shift = (seg < 3'h2) ? 4'h1 : {1'b0, seg};
        end
        mant = 4'(mag >> shift);
        if (mu) begin
            o_code = {1'b0, seg, mant} ^ (neg ? 8'h7f : 8'hff);
        end else begin
            o_code = {1'b0, seg, mant} ^ (neg ? 8'h55 : 8'hd5);
        end
    end
endmodule

// File: rtl/tdmcs_pkg.sv
package tdmcs_pkg;
    localparam int         CLK_PERIOD_NS  = 25;
    localparam int         BCLK_HALF_NS   = 250;
    localparam int         BCLK_HALF_CYC  = BCLK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [7:0] FRAME_LAST_BIT = 8'hff;
    localparam logic [3:0] BIT_LAST       = 4'hf;
    localparam logic [3:0] SLOT_CMD       = 4'h0;
    localparam logic [3:0] SLOT_VALUE     = 4'h1;
    localparam logic [3:0] SLOT_ADC_BASE  = 4'h2;
    localparam logic [3:0] SLOT_LAST_USED = 4'h9;
    localparam int         CMD_OP_BIT     = 15;
    localparam int         CMD_AHI_BIT    = 14;
    localparam int         CMD_ALO_BIT    = 13;
    localparam int         CMD_REG_MSB    = 12;
    localparam int         CMD_REG_LSB    = 5;
    localparam int         NUM_REGS       = 18;
    localparam logic [7:0] REG_VALID_CFG  = 8'h0d;
    localparam logic [7:0] REG_CODING_CFG = 8'h0f;
    localparam logic [7:0] REG_INTERVAL   = 8'h11;
    localparam int         VALID_EN_BIT   = 0;
    localparam int         CODING_LSB     = 6;
    localparam logic [7:0] RST_VALID_CFG  = 8'h01;
    localparam logic [7:0] RST_OTHER      = 8'h00;
    localparam logic [7:0] RST_INTERVAL   = 8'h00;
    localparam logic [1:0] CODING_LINEAR  = 2'h0;
    localparam logic [1:0] CODING_ALAW    = 2'h1;
    localparam logic [1:0] CODING_MULAW   = 2'h2;
    localparam logic [6:0] MU_BIAS        = 7'h21;
    localparam logic [15:0] MU_CLIP       = 16'h1fff;
endpackage

// File: rtl/tdmcs_port.sv
module tdmcs_port (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // straps and control select
    input  wire logic        i_master,
    input  wire logic        i_addr_strap_high,
    input  wire logic        i_addr_strap_low,
    input  wire logic        i_ctl_sel_n,
    // bit clock pin
    input  wire logic        i_bclk,
    output logic             o_bclk,
    output logic             o_bclk_oe_n,
    // frame pulse pin
    input  wire logic        i_frame_pulse,
    output logic             o_frame_pulse,
    output logic             o_frame_pulse_oe_n,
    // serial data pins
    input  wire logic        i_sdin,
    output logic             o_sdout,
    output logic             o_sdout_oe_n,
    // adc samples
    input  wire logic [15:0] i_adc1_sample,
    input  wire logic [15:0] i_adc2_sample,
    output logic      [1:0]  o_adc_load,
    // dac words
    output logic      [15:0] o_dac1_word,
    output logic      [15:0] o_dac2_word,
    output logic      [1:0]  o_dac_strobe,
    // register updates
    output logic             o_reg_wr,
    output logic      [7:0]  o_reg_wr_addr,
    output logic      [7:0]  o_reg_wr_data,
    output logic      [1:0]  o_coding
);
    import tdmcs_pkg::*;

    typedef struct packed {
        logic                 bclk_q;
        logic                 synced;
        logic [7:0]           cnt;
        logic [15:0]          rx_sh;
        logic [15:0]          tx_sh;
        logic                 sdout;
        logic                 drive;
        logic [7:0]           skip;
        logic                 ctl_ok;
        logic                 cmd_hit;
        logic                 cmd_wr;
        logic [7:0]           cmd_addr;
        logic [17:0][7:0]     regs;
        logic [1:0][15:0]     dac;
        logic [1:0]           dac_stb;
        logic [1:0]           adc_ld;
        logic                 wr_stb;
        logic [7:0]           wr_addr;
        logic [7:0]           wr_data;
    } tdmcs_state_s;

    tdmcs_state_s s;
    tdmcs_state_s next_s;

    logic             gen_bclk;
    logic             gen_fp;
    logic             bclk;
    logic             fp;
    logic             rise;
    logic             fall;
    logic             ctl_en;
    logic [1:0]       strap;
    logic [3:0]       slot_a;
    logic [3:0]       slot_b;
    logic [1:0][15:0] adc_in;
    logic [1:0][7:0]  adc_code;
    logic [1:0]       coding;
    logic             flag_en;

    tdmcs_clkgen u_clkgen (
        .i_clk         (i_clk),
        .i_reset       (i_reset),
        .i_master      (i_master),
        .o_bclk        (gen_bclk),
        .o_frame_pulse (gen_fp)
    );

    assign adc_in[0] = i_adc1_sample;
    assign adc_in[1] = i_adc2_sample;

    for (genvar c = 0; c < 2; c++) begin : g_enc
        tdmcs_compand u_enc (
            .i_sample (adc_in[c]),
            .i_coding (coding),
            .o_code   (adc_code[c])
        );
    end

    function automatic logic [7:0] reg_read(input logic [17:0][7:0] r,
                                            input logic [7:0] a);
        reg_read = (a < 8'(NUM_REGS)) ? r[a[4:0]] : 8'h00;
    endfunction

    function automatic logic [15:0] adc_fmt(input logic [15:0] lin,
                                            input logic [7:0] code,
                                            input logic [1:0] cod,
                                            input logic flag);
        if (cod == CODING_LINEAR) begin
            adc_fmt = flag ? {1'b1, lin[15:1]} : lin;
        end else begin
            adc_fmt = {flag, 7'h00, code};
        end
    endfunction

    // slave strap takes the pins, master uses the local generator
    assign bclk    = i_master ? gen_bclk : i_bclk;
    assign fp      = i_master ? gen_fp : i_frame_pulse;
    assign rise    = bclk & ~s.bclk_q;
    assign fall    = ~bclk & s.bclk_q;
    assign ctl_en  = ~i_ctl_sel_n;
    assign strap   = {i_addr_strap_high, i_addr_strap_low};
    assign slot_a  = 4'(SLOT_ADC_BASE + {1'b0, strap, 1'b0});
    assign slot_b  = 4'(slot_a + 4'h1);
    assign coding  = s.regs[REG_CODING_CFG[4:0]][CODING_LSB +: 2];
    assign flag_en = s.regs[REG_VALID_CFG[4:0]][VALID_EN_BIT];

    always_comb begin
        logic [15:0] word;
        logic [15:0] tx;
        logic        drv;
        logic [3:0]  slot;
        logic [7:0]  val;
        word           = {s.rx_sh[14:0], i_sdin};
        tx             = 16'h0000;
        drv            = 1'b0;
        slot           = s.cnt[7:4];
        val            = word[15:8];
        next_s         = s;
        next_s.bclk_q  = bclk;
        next_s.dac_stb = 2'b00;
        next_s.adc_ld  = 2'b00;
        next_s.wr_stb  = 1'b0;
        if (fall) begin
            if (fp) begin
                next_s.cnt    = FRAME_LAST_BIT;
                next_s.synced = 1'b1;
            end else if (s.synced) begin
                next_s.rx_sh = word;
                if (s.cnt[3:0] == BIT_LAST) begin
                    if (slot == SLOT_CMD) begin
                        next_s.cmd_hit  = ctl_en && s.ctl_ok
                            && word[CMD_AHI_BIT] == strap[1]
                            && word[CMD_ALO_BIT] == strap[0];
                        next_s.cmd_wr   = word[CMD_OP_BIT];
                        next_s.cmd_addr =
                            word[CMD_REG_MSB:CMD_REG_LSB];
                    end else if (slot == SLOT_VALUE) begin
                        if (s.cmd_hit && s.cmd_wr && s.cmd_addr != 8'h00
                            && s.cmd_addr < 8'(NUM_REGS)) begin
                            next_s.regs[s.cmd_addr[4:0]] = val;
                            next_s.wr_stb  = 1'b1;
                            next_s.wr_addr = s.cmd_addr;
                            next_s.wr_data = val;
                            if (s.cmd_addr == REG_INTERVAL) begin
                                next_s.skip = (val == 8'h00) ? 8'h00
                                    : 8'(val - 8'h01);
                            end
                        end
                    end else if (slot == slot_a) begin
                        next_s.dac[0]     = word;
                        next_s.dac_stb[0] = 1'b1;
                    end else if (slot == slot_b) begin
                        next_s.dac[1]     = word;
                        next_s.dac_stb[1] = 1'b1;
                    end
                end
            end
        end
        if (rise && s.synced) begin
            next_s.cnt = 8'(s.cnt + 8'h01);
            slot       = next_s.cnt[7:4];
            if (next_s.cnt == 8'h00) begin
                next_s.ctl_ok  = (s.skip == 8'h00);
                next_s.skip    = next_s.ctl_ok ? reg_read(s.regs,
                                   REG_INTERVAL) : 8'(s.skip - 8'h01);
                next_s.cmd_hit = 1'b0;
            end
            if (next_s.cnt[3:0] == 4'h0) begin
                if (slot == SLOT_CMD) begin
                    drv = ctl_en && next_s.ctl_ok;
                end else if (slot == SLOT_VALUE) begin
                    drv = s.cmd_hit;
                    tx  = s.cmd_wr ? 16'h0000
                        : {reg_read(s.regs, s.cmd_addr), 8'h00};
                end else if (slot == slot_a) begin
                    drv              = 1'b1;
                    tx               = adc_fmt(i_adc1_sample, adc_code[0],
                                               coding, flag_en);
                    next_s.adc_ld[0] = 1'b1;
                end else if (slot == slot_b) begin
                    drv              = 1'b1;
                    tx               = adc_fmt(i_adc2_sample, adc_code[1],
                                               coding, flag_en);
                    next_s.adc_ld[1] = 1'b1;
                end
                // other slots, 10 to 15 included, stay released
                next_s.drive = drv;
                next_s.sdout = tx[15];
                next_s.tx_sh = {tx[14:0], 1'b0};
            end else begin
                next_s.sdout = s.tx_sh[15];
                next_s.tx_sh = {s.tx_sh[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s                             <= '0;
            s.regs                        <= {NUM_REGS{RST_OTHER}};
            s.regs[REG_VALID_CFG[4:0]]    <= RST_VALID_CFG;
            s.regs[REG_INTERVAL[4:0]]     <= RST_INTERVAL;
        end else begin
            s <= next_s;
        end
    end

    assign o_bclk             = gen_bclk;
    assign o_bclk_oe_n        = ~i_master;
    assign o_frame_pulse      = gen_fp;
    assign o_frame_pulse_oe_n = ~i_master;
    assign o_sdout            = s.sdout;
    assign o_sdout_oe_n       = ~s.drive;
    assign o_adc_load         = s.adc_ld;
    assign o_dac1_word        = s.dac[0];
    assign o_dac2_word        = s.dac[1];
    assign o_dac_strobe       = s.dac_stb;
    assign o_reg_wr           = s.wr_stb;
    assign o_reg_wr_addr      = s.wr_addr;
    assign o_reg_wr_data      = s.wr_data;
    assign o_coding           = coding;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    bit_count_a: assert property ((rise && s.synced) |=>
        s.cnt == 8'($past(s.cnt) + 8'h01))
        else $error("bit counter did not advance on rise");
    frame_align_a: assert property ((fall && fp) |=>
        (s.cnt == FRAME_LAST_BIT && s.synced))
        else $error("frame pulse did not align the counter");
    msb_first_a: assert property (
        (rise && s.synced && s.cnt[3:0] != BIT_LAST)
        |=> o_sdout == $past(s.tx_sh[15]))
        else $error("serial output not msb first");
    out_on_rise_a: assert property ($changed(o_sdout) |->
        $past(rise))
        else $error("serial output changed off a rising edge");
    idle_slots_a: assert property ((s.cnt[7:4] > SLOT_LAST_USED) |->
        o_sdout_oe_n)
        else $error("output driven in an unused slot");
    slot_zero_a: assert property (
        (s.cnt[7:4] == SLOT_CMD && !o_sdout_oe_n) |-> !o_sdout)
        else $error("slot 0 output not zero");
    own_slots_a: assert property (
        (!o_sdout_oe_n && s.cnt[7:4] > SLOT_VALUE)
        |-> (s.cnt[7:4] == slot_a || s.cnt[7:4] == slot_b))
        else $error("output driven in a foreign data slot");
    ctl_select_a: assert property (
        (fall && s.synced && i_ctl_sel_n && s.cnt == 8'h0f) |=> !s.cmd_hit)
        else $error("command taken with control select high");
    addr_zero_a: assert property (s.wr_stb |-> s.wr_addr != 8'h00)
        else $error("register zero was written");
    interval_a: assert property (
        (rise && s.synced && s.cnt == FRAME_LAST_BIT && s.skip != 8'h00)
        |=> (!s.ctl_ok && s.skip == 8'($past(s.skip) - 8'h01)))
        else $error("control interval not counted down");
    master_pins_a: assert property (i_master |->
        (!o_bclk_oe_n && !o_frame_pulse_oe_n))
        else $error("master does not drive link timing");
    slave_pins_a: assert property (!i_master |->
        (o_bclk_oe_n && o_frame_pulse_oe_n))
        else $error("slave drives link timing");

    // command slots
    read_answer_a: assert property (
        (rise && s.synced && s.cnt == 8'h0f && s.cmd_hit) |=> !o_sdout_oe_n)
        else $error("matched read not answered in slot 1");
    foreign_cmd_a: assert property (
        (rise && s.synced && s.cnt == 8'h0f && !s.cmd_hit) |=> o_sdout_oe_n)
        else $error("slot 1 driven without a matched command");
    write_cmd_a: assert property (
        o_reg_wr |-> $past(s.cmd_hit && s.cmd_wr))
        else $error("register written without a write command");
    read_nowrite_a: assert property (
        (fall && s.synced && s.cnt == 8'h1f && !s.cmd_wr) |=> !o_reg_wr)
        else $error("read command wrote a register");
    interval_load_a: assert property (
        (o_reg_wr && o_reg_wr_addr == REG_INTERVAL && o_reg_wr_data != 8'h00)
        |-> s.skip == 8'(o_reg_wr_data - 8'h01))
        else $error("first control gap not one short");
    cmd_clear_a: assert property (
        (rise && s.synced && s.cnt == FRAME_LAST_BIT) |=> !s.cmd_hit)
        else $error("command carried into the next frame");
    skip_ignore_a: assert property (
        (fall && s.synced && !s.ctl_ok && s.cnt == 8'h0f) |=> !s.cmd_hit)
        else $error("command taken in a skipped frame");
    slot_zero_drive_a: assert property (
        (rise && s.synced && s.cnt == FRAME_LAST_BIT && !i_ctl_sel_n
            && s.skip == 8'h00) |=> (!o_sdout_oe_n && !o_sdout))
        else $error("slot 0 not driven as zero");

    // data slots
    codec1_slot_a: assert property (
        (rise && s.synced && s.cnt[3:0] == BIT_LAST
            && 4'(s.cnt[7:4] + 4'h1) == slot_a)
        |=> (!o_sdout_oe_n && o_adc_load[0]))
        else $error("first codec slot not driven");
    codec2_slot_a: assert property (
        (rise && s.synced && s.cnt[3:0] == BIT_LAST
            && 4'(s.cnt[7:4] + 4'h1) == slot_b)
        |=> (!o_sdout_oe_n && o_adc_load[1]))
        else $error("second codec slot not driven");
    dac1_slot_a: assert property (
        o_dac_strobe[0] |-> $past(fall && s.cnt == {slot_a, BIT_LAST}))
        else $error("first dac word taken outside its slot");
    dac2_slot_a: assert property (
        o_dac_strobe[1] |-> $past(fall && s.cnt == {slot_b, BIT_LAST}))
        else $error("second dac word taken outside its slot");
    unused_release_a: assert property (
        (rise && s.synced && s.cnt == 8'h9f) |=> o_sdout_oe_n)
        else $error("output not released after the data slots");
    unsynced_quiet_a: assert property (
        !s.synced |-> o_sdout_oe_n)
        else $error("output driven before the first frame pulse");

    write_hit_c: cover property (s.wr_stb);
    read_hit_c: cover property (s.cmd_hit && !s.cmd_wr && !o_sdout_oe_n
        && s.cnt[7:4] == SLOT_VALUE);
    dac_rx_c: cover property (s.dac_stb[1]);
    ctl_skip_c: cover property (rise && s.cnt == FRAME_LAST_BIT
        && s.skip != 8'h00);
    master_frame_c: cover property (i_master && gen_fp);
endmodule

// File: testbench/tb_tdmcs_port.sv
module tb_tdmcs_port;
    timeunit 1ns;
    timeprecision 100ps;
    import tdmcs_pkg::*;

    logic         clk, rst, master, ahi, alo, ctl_n, run, p;
    logic [15:0]  adc1, adc2, dac1, dac2, tx [16];
    logic [255:0] txf, rx, rx_en;
    logic         h_bclk, h_fp, sdin, done, d_bclk, bclk_oe_n;
    logic         d_fp, fp_oe_n, sdout, sdout_oe_n, reg_wr;
    logic [1:0]   coding;
    logic [7:0]   wr_addr, wr_data;
    int           err_count, total_checks, wr_cnt, n, r;
    wire          bclk_w = bclk_oe_n ? h_bclk : d_bclk;
    wire          fp_w   = fp_oe_n ? h_fp : d_fp;

    always #12.5 clk = ~clk;

    always_comb begin
        for (int k = 0; k < 16; k++) txf[16 * (15 - k) +: 16] = tx[k];
    end

    always @(posedge clk) begin
        if (rst) wr_cnt <= 0;
        else if (reg_wr === 1'b1) wr_cnt <= wr_cnt + 1;
    end

    tdmcs_port tdmcs_port_i (
        .i_clk(clk), .i_reset(rst), .i_master(master),
        .i_addr_strap_high(ahi), .i_addr_strap_low(alo),
        .i_ctl_sel_n(ctl_n), .i_bclk(bclk_w), .o_bclk(d_bclk),
        .o_bclk_oe_n(bclk_oe_n), .i_frame_pulse(fp_w),
        .o_frame_pulse(d_fp), .o_frame_pulse_oe_n(fp_oe_n),
        .i_sdin(sdin), .o_sdout(sdout), .o_sdout_oe_n(sdout_oe_n),
        .i_adc1_sample(adc1), .i_adc2_sample(adc2), .o_adc_load(),
        .o_dac1_word(dac1), .o_dac2_word(dac2), .o_dac_strobe(),
        .o_reg_wr(reg_wr), .o_reg_wr_addr(wr_addr),
        .o_reg_wr_data(wr_data), .o_coding(coding)
    );

    tdmcs_host_model tdmcs_host_model_i (
        .i_clk(clk), .i_run(run), .i_tx(txf), .i_sdout(sdout),
        .i_sdout_oe_n(sdout_oe_n), .o_bclk(h_bclk),
        .o_frame_pulse(h_fp), .o_sdin(sdin), .o_rx(rx),
        .o_rx_en(rx_en), .o_done(done)
    );

    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] slot(input int s);
        return rx[16 * (15 - s) +: 16];
    endfunction

    function automatic logic [15:0] en(input int s);
        return rx_en[16 * (15 - s) +: 16];
    endfunction

    function automatic logic [15:0] cmd(input logic op, input logic [1:0] a,
                                        input logic [7:0] rg);
        return {op, a, rg, 5'h00};
    endfunction

    // waits for the end of a host frame, then steps to a rising edge
    task automatic wait_done();
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (done !== 1'b1 && t < 3000);
        if (t >= 3000) err_count++;
        @(posedge clk);
    endtask

    task automatic frame(input logic [15:0] c0, input logic [15:0] c1,
                         input int wr);
        int m;
        m = wr_cnt;
        tx[0] <= c0;
        tx[1] <= c1;
        wait_done();
        chk(16'(wr_cnt - m), 16'(wr));
    endtask

    task automatic t_reset();
        chk(16'(sdout_oe_n), 16'h0001);
        chk(16'({bclk_oe_n, fp_oe_n}), 16'h0003);
        chk(16'(coding), 16'(CODING_LINEAR));
        run <= 1'b1;
        wait_done();
    endtask

    task automatic t_data();
        frame(cmd(1'b0, 2'h2, REG_VALID_CFG), 16'h0000, 0);
        chk(slot(0), 16'h0000);
        chk(en(0), 16'hffff);
        chk(slot(1), {RST_VALID_CFG, 8'h00});
        chk(slot(6), {1'b1, adc1[15:1]});
        chk(slot(7), {1'b1, adc2[15:1]});
        chk(en(6) & en(7), 16'hffff);
        for (int s = 2; s < 16; s++) begin
            if (s != 6 && s != 7) chk(en(s), 16'h0000);
        end
        chk(dac1, 16'h1234);
        chk(dac2, 16'hfe01);
    endtask

    task automatic t_coding();
        frame(cmd(1'b1, 2'h2, REG_CODING_CFG), 16'h8000, 1);
        chk({wr_addr, wr_data}, {REG_CODING_CFG, 8'h80});
        chk(16'(coding), 16'(CODING_MULAW));
        chk(slot(1), 16'h0000);
        frame(cmd(1'b0, 2'h1, REG_CODING_CFG), 16'h0000, 0);
        chk(en(1), 16'h0000);
        chk(slot(6) & 16'hff00, 16'h8000);
        frame(cmd(1'b1, 2'h3, REG_CODING_CFG), 16'h0000, 0);
        chk(16'(coding), 16'(CODING_MULAW));
    endtask

    task automatic t_flags();
        frame(cmd(1'b1, 2'h2, REG_VALID_CFG), 16'h0000, 1);
        frame(cmd(1'b1, 2'h2, 8'h00), 16'hff00, 0);
        chk(slot(6) & 16'hff00, 16'h0000);
        ctl_n <= 1'b1;
        frame(cmd(1'b1, 2'h2, REG_CODING_CFG), 16'h0000, 0);
        ctl_n <= 1'b0;
        chk(16'(coding), 16'(CODING_MULAW));
        frame(cmd(1'b1, 2'h2, REG_CODING_CFG), 16'h0000, 1);
        chk(16'(coding), 16'(CODING_LINEAR));
        frame(cmd(1'b0, 2'h2, REG_INTERVAL), 16'h0000, 0);
        chk(slot(1), {RST_INTERVAL, 8'h00});
        chk(slot(6), adc1);
    endtask

    task automatic t_interval();
        frame(cmd(1'b1, 2'h2, REG_INTERVAL), 16'h0200, 1);
        for (int k = 0; k < 4; k++) begin
            frame(cmd(1'b1, 2'h2, REG_CODING_CFG), 16'h4000, k == 1);
        end
        chk(16'(coding), 16'(CODING_ALAW));
        frame(cmd(1'b1, 2'h2, REG_INTERVAL), 16'h0000, 1);
        frame(cmd(1'b1, 2'h2, REG_CODING_CFG), 16'h0000, 1);
    endtask

    task automatic tick();
        @(negedge clk);
        n++;
        if (d_bclk === 1'b1 && p === 1'b0) r++;
        p = d_bclk;
    endtask

    task automatic t_master();
        run <= 1'b0;
        rst <= 1'b1;
        master <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(16'({bclk_oe_n, fp_oe_n}), 16'h0000);
        n = 0;
        while (d_fp !== 1'b1 && n < 9000) tick();
        n = 0;
        r = 0;
        while (d_fp === 1'b1 && n < 9000) tick();
        chk(16'(n), 16'h0014);
        while (d_fp !== 1'b1 && n < 9000) tick();
        chk(16'(n), 16'h1400);
        chk(16'(r), 16'h0100);
    endtask

    initial begin
        #1500000;
        err_count++;
        finish_test();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        master = 1'b0;
        ahi = 1'b1;
        alo = 1'b0;
        ctl_n = 1'b0;
        run = 1'b0;
        p = 1'b0;
        adc1 = 16'h8a5d;
        adc2 = 16'h3c21;
        for (int k = 0; k < 16; k++) tx[k] = 16'ha5a5;
        tx[6] = 16'h1234;
        tx[7] = 16'hfe01;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_data();
        t_coding();
        t_flags();
        t_interval();
        t_master();
        finish_test();
    end
endmodule

// File: testbench/tdmcs_host_model.sv
module tdmcs_host_model (
    // clock
    input  wire logic         i_clk,
    // frame control from the bench
    input  wire logic         i_run,
    input  wire logic [255:0] i_tx,
    // device serial output
    input  wire logic         i_sdout,
    input  wire logic         i_sdout_oe_n,
    // link towards the device
    output logic              o_bclk,
    output logic              o_frame_pulse,
    output logic              o_sdin,
    // captured frame, word 0 in the top bits
    output logic      [255:0] o_rx,
    output logic      [255:0] o_rx_en,
    output logic              o_done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] ph;
    logic [7:0] bitn;

    // bit clock of eight system clocks; stands still outside frames
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (!i_run) begin
            ph <= 3'h0;
            bitn <= 8'hff;
            o_bclk <= 1'b0;
            o_frame_pulse <= 1'b0;
            o_sdin <= (o_sdin !== 1'b1);
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h0) begin
                o_bclk <= 1'b1;
                o_frame_pulse <= (bitn == 8'hff);
                o_sdin <= i_tx[8'hff - bitn];
            end
            if (ph == 3'h4) begin
                o_bclk <= 1'b0;
                o_rx[8'hff - bitn] <= i_sdout;
                o_rx_en[8'hff - bitn] <= ~i_sdout_oe_n;
                o_done <= (bitn == 8'hff);
                bitn <= bitn + 8'h01;
            end
        end
    end
endmodule
